// ===== logic/gpmap_pkg.sv
// Purpose: Shared constants for the general purpose pin map block.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Input indices and widths used by the main file; the filter imports them but uses none.
package gpmap_pkg;
	localparam int unsigned GPMAP_NUM_IN        = 16;
	localparam int unsigned GPMAP_ALERT_IDX     = 11;
	localparam int unsigned GPMAP_GFXBUSY_IDX   = 6;
	localparam int unsigned GPMAP_STICKY_LO     = 1;
	localparam int unsigned GPMAP_MIN_ACTIVE_CK = 2;
	localparam int unsigned GPMAP_SYNC_STAGES   = 3;
	localparam logic [15:0] GPMAP_NATIVE_RST    = 16'hFFFF;
	localparam logic [15:0] GPMAP_ZERO16        = 16'h0000;
	localparam logic [1:0]  GPMAP_ROUTE_NONE    = 2'h0;
	localparam logic [1:0]  GPMAP_ROUTE_SMI     = 2'h1;
	localparam logic [1:0]  GPMAP_ROUTE_SCI     = 2'h2;
endpackage : gpmap_pkg

// ===== logic/gpmap_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes:   Output changes only when the second and third stages agree.
`timescale 1ns/1ps
module gpmap_sync
	import gpmap_pkg::*;
#(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic             sys_clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] async_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] next_sync;

	assign agree     = ~(stage2 ^ stage3);
	assign next_sync = (agree & stage3) | (~agree & sync_o);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_o <= next_sync;
		end
	end
	// rst_val_i is unused by design; reset values are constants.
	logic unused_rst;
	assign unused_rst = ^rst_val_i;
endmodule : gpmap_sync

// ===== logic/gpmap_top.sv
// Purpose: General purpose input routing, sticky status, alert events and
//          configuration-dependent pin roles of the I/O hub pin map.
// Assumes: Board pins are asynchronous; config strap and native-select,
//          level and routing settings come from logic on sys_clk_i.
// Notes:   No software registers; settings are plain ports.
// Behaviour
// - In G1 or hung G0, any level change on the alert input raises an event.
// - Input 11 alert event occurs whether pin is general-purpose or native.
// - Mobile configuration: output 21 is active-low deep-sleep transition indicator.
// - Desktop configuration: output 21 is decode inhibit for subtractive decode.
// - Input 6 role follows strap; mobile receives graphics busy from memory hub.
// - After reset every multiplexed pin comes up in its native function.
// - Inputs 0..15 route to management interrupt, control interrupt, or neither.
// - Inputs 1..15 active two clocks set sticky status until cleared.
`timescale 1ns/1ps
module gpmap_top
	import gpmap_pkg::*;
#(
	parameter int unsigned NUM_IN = GPMAP_NUM_IN
) (
	input  wire logic              sys_clk_i,
	input  wire logic              srst_i,
	input  wire logic [NUM_IN-1:0] general_input_i,
	input  wire logic              mobile_cfg_i,
	input  wire logic              heartbeat_mode_i,
	input  wire logic [NUM_IN-1:0] gp_select_i,
	input  wire logic              gp_select_we_i,
	input  wire logic [NUM_IN-1:0] active_high_i,
	input  wire logic [NUM_IN-1:0] route_smi_i,
	input  wire logic [NUM_IN-1:0] route_sci_i,
	input  wire logic [NUM_IN-1:0] sticky_clr_i,
	input  wire logic              deep_sleep_req_i,
	input  wire logic              decode_inhibit_req_i,
	input  wire logic              general_output21_i,
	output logic      [NUM_IN-1:0] native_sel_o,
	output logic      [NUM_IN-1:0] sticky_sts_o,
	output logic                   system_mgmt_interrupt_n_o,
	output logic                   acpi_control_interrupt_o,
	output logic                   alert_event_o,
	output logic                   alert_level_o,
	output logic                   pin21_o,
	output logic                   deep_sleep_transition_n_o,
	output logic                   decode_inhibit_o,
	output logic                   graphics_busy_n_o,
	output logic                   graphics_busy_valid_o
);
	logic [NUM_IN-1:0] in_sync;
	logic [NUM_IN-1:0] prev_sync;
	logic [NUM_IN-1:0] active_now;
	logic [NUM_IN-1:0] active_two;
	logic [NUM_IN-1:0] sticky_mask;
	logic [NUM_IN-1:0] gp_role;
	logic [NUM_IN-1:0] smi_route;
	logic [NUM_IN-1:0] sci_route;
	logic [NUM_IN-1:0] next_sticky;
	logic              alert_change;
	logic              next_pin21;

	// Pin inputs cross into the clock domain here. The path from a pin to
	// in_sync is four edges: three flops, then the agreement filter. Every
	// output below adds one more register. Board logic that pulses a pin for
	// less than about two clocks may therefore see no reaction at all.
	gpmap_sync #(
		.WIDTH     (NUM_IN)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.async_i   (general_input_i),
		.rst_val_i (GPMAP_ZERO16[NUM_IN-1:0]),
		.sync_o    (in_sync)
	);

	// Native select is one per pin; a set bit means native function.
	// The whole word is loaded at once, so a partial update is not possible;
	// the settings logic must present the full role map with the strobe.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			native_sel_o <= GPMAP_NATIVE_RST[NUM_IN-1:0];
		end else if (gp_select_we_i) begin
			native_sel_o <= ~gp_select_i;
		end
	end

	// Level compare against the per-pin polarity. It is applied to the
	// current and to the previous synchronised sample alike.
	function automatic logic [NUM_IN-1:0] level_match(
		input logic [NUM_IN-1:0] sample,
		input logic [NUM_IN-1:0] polarity
	);
		return ~(sample ^ polarity);
	endfunction : level_match

	// A pin in its general-purpose role is one whose native select is clear.
	// Interrupt routing only looks at such pins.
	assign gp_role = ~native_sel_o;

	// Current and previous synchronised samples, each matched against the
	// selected active level of its own pin.
	logic [NUM_IN-1:0] prev_active;
	assign active_now  = level_match(in_sync, active_high_i);
	assign prev_active = level_match(prev_sync, active_high_i);

	// Two consecutive synchronised samples at the active level are needed.
	// A shorter pulse may be missed, so board logic must hold a level for
	// at least two clocks after it has crossed the synchroniser.
	assign active_two = active_now & prev_active;

	// Input 0 has no sticky status bit, so its lane is masked off here.
	assign sticky_mask = {{(NUM_IN-GPMAP_STICKY_LO){1'b1}}, {GPMAP_STICKY_LO{1'b0}}};

	// Set wins over clear so an event in the clear cycle is kept. The cost
	// is that a pin held active keeps its bit set through any clear.
	logic [NUM_IN-1:0] sticky_keep;
	logic [NUM_IN-1:0] sticky_set;
	assign sticky_keep = sticky_sts_o & ~sticky_clr_i;
	assign sticky_set  = active_two & sticky_mask;
	assign next_sticky = sticky_keep | sticky_set;

	// SMI takes precedence so a pin never reaches both interrupts.
	// Software that sets both routing bits gets the management interrupt.
	assign smi_route = route_smi_i & gp_role & active_now;
	assign sci_route = route_sci_i & ~route_smi_i & gp_role & active_now;

	// The alert watches the pin regardless of its native or general role,
	// since the heartbeat logic must report transitions in either case.
	logic alert_now;
	logic alert_prev;
	assign alert_now    = in_sync[GPMAP_ALERT_IDX];
	assign alert_prev   = prev_sync[GPMAP_ALERT_IDX];
	assign alert_change = heartbeat_mode_i & (alert_now ^ alert_prev);

	// Output 21 has two native meanings chosen by the platform strap.
	// The strap is expected to be static; a change while the pin is in use
	// is passed through at once and may glitch the external signal.
	logic pin21_mobile;
	logic pin21_desktop;
	assign pin21_mobile  = ~deep_sleep_req_i;
	assign pin21_desktop = decode_inhibit_req_i;
	assign next_pin21    = mobile_cfg_i ? pin21_mobile : pin21_desktop;

	// Status, interrupt and alert registers. The interrupt outputs are
	// levels that follow the routed pins; they are not latched, so a handler
	// reads the sticky status to learn about short events.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prev_sync                 <= '0;
			sticky_sts_o              <= '0;
			system_mgmt_interrupt_n_o <= 1'b1;
			acpi_control_interrupt_o  <= 1'b0;
			alert_event_o             <= 1'b0;
			alert_level_o             <= 1'b0;
		end else begin
			prev_sync                 <= in_sync;
			sticky_sts_o              <= next_sticky;
			system_mgmt_interrupt_n_o <= ~(|smi_route);
			acpi_control_interrupt_o  <= |sci_route;
			alert_event_o             <= alert_change;
			alert_level_o             <= in_sync[GPMAP_ALERT_IDX];
		end
	end

	// Pin 21 is high in reset; after reset it idles high when mobile and low when desktop.
	// The dedicated deep-sleep and decode-inhibit outputs are kept beside the
	// shared pin so that neighbouring logic need not decode the strap again.
	// Graphics busy is passed on in either configuration, but is only
	// qualified as valid in the mobile configuration with its native role.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pin21_o                   <= 1'b1;
			deep_sleep_transition_n_o <= 1'b1;
			decode_inhibit_o          <= 1'b0;
			graphics_busy_n_o         <= 1'b1;
			graphics_busy_valid_o     <= 1'b0;
		end else begin
			pin21_o                   <= native_sel_o[NUM_IN-1] ? next_pin21
			                                                    : general_output21_i;
			deep_sleep_transition_n_o <= mobile_cfg_i ? ~deep_sleep_req_i : 1'b1;
			decode_inhibit_o          <= mobile_cfg_i ? 1'b0 : decode_inhibit_req_i;
			graphics_busy_n_o         <= in_sync[GPMAP_GFXBUSY_IDX];
			graphics_busy_valid_o     <= mobile_cfg_i & native_sel_o[GPMAP_GFXBUSY_IDX];
		end
	end
endmodule : gpmap_top

// ===== testbench/gpmap_board.sv
// Purpose: Board side of the general input pins.
// Assumes: Levels are set by the bench.
// Notes: A fixed skew keeps pin edges off the clock edge.
`timescale 1ns/1ps
module gpmap_board (
	input	wire logic [15:0]	level_i,
	output	logic [15:0]	pin_o
);
	initial pin_o = '0;
	always @(level_i) pin_o <= #3 level_i;
endmodule : gpmap_board

// ===== testbench/gpmap_sva.sv
// Purpose: Port assertions for the pin map.
// Assumes: Bound to gpmap_top with its default width.
// Notes: Input causes use two samples to allow one register stage.
`timescale 1ns/1ps
module gpmap_sva (
	input	wire logic	sys_clk_i,
	input	wire logic	srst_i,
	input	wire logic	heartbeat_mode_i,
	input	wire logic	mobile_cfg_i,
	input	wire logic	deep_sleep_req_i,
	input	wire logic	decode_inhibit_req_i,
	input	wire logic	system_mgmt_interrupt_n_o,
	input	wire logic	alert_event_o,
	input	wire logic	deep_sleep_transition_n_o,
	input	wire logic	decode_inhibit_o,
	input	wire logic [15:0]	route_smi_i,
	input	wire logic [15:0]	sticky_clr_i,
	input	wire logic [15:0]	native_sel_o,
	input	wire logic [15:0]	sticky_sts_o
);
	logic	rp;
	always_ff @(posedge sys_clk_i) rp <= srst_i;
	default clocking @(posedge sys_clk_i); endclocking
	// The cycle after reset still sees reset-time inputs through $past.
	default disable iff (srst_i || rp);
	sequence s_pulse;
		alert_event_o ##1 !alert_event_o;
	endsequence
	a_reset_native: assert property (disable iff (1'b0) srst_i |=> &native_sel_o)
		else $error("native not set");
	a_bit0_clear: assert property (!sticky_sts_o[0])
		else $error("bit 0 set");
	a_sticky_holds: assert property (!(~sticky_sts_o & $past(sticky_sts_o)
		& ~$past(sticky_clr_i) & ~$past(sticky_clr_i, 2))) else $error("sticky lost");
	a_smi_unrouted: assert property (!route_smi_i && !$past(route_smi_i)
		|-> system_mgmt_interrupt_n_o) else $error("smi unrouted");
	a_alert_quiet: assert property (!heartbeat_mode_i && !$past(heartbeat_mode_i)
		|-> !alert_event_o) else $error("alert idle");
	a_alert_pulse: assert property (alert_event_o |-> s_pulse)
		else $error("alert long");
	a_deep_sleep: assert property ($past(mobile_cfg_i && deep_sleep_req_i)
		|-> !deep_sleep_transition_n_o) else $error("deep sleep");
	a_inhibit_shown: assert property ($past(!mobile_cfg_i && decode_inhibit_req_i)
		|-> decode_inhibit_o) else $error("inhibit");
endmodule : gpmap_sva
bind gpmap_top gpmap_sva gpmap_sva_i (.*);

// ===== testbench/gpmap_top_tb.sv
// Purpose: Self-checking bench for the pin map.
// Assumes: Pins reach the block through gpmap_board.
// Notes: Waits are long so the four-edge input path settles.
`timescale 1ns/1ps
module gpmap_top_tb;
	import gpmap_pkg::*;
	logic	sys_clk_i = '0, srst_i = '1, mobile_cfg_i = '0, heartbeat_mode_i = '0;
	logic	gp_select_we_i = '0, deep_sleep_req_i = '0, decode_inhibit_req_i = '0;
	logic	general_output21_i = '0, system_mgmt_interrupt_n_o, acpi_control_interrupt_o;
	logic	alert_event_o, alert_level_o, pin21_o, deep_sleep_transition_n_o;
	logic	decode_inhibit_o, graphics_busy_n_o, graphics_busy_valid_o;
	logic [15:0]	pins = '0, gp_select_i = '0, active_high_i = '1, route_smi_i = '0;
	logic [15:0]	route_sci_i = '0, sticky_clr_i = '0, acnt = '0;
	logic [15:0]	general_input_i, native_sel_o, sticky_sts_o;
	logic [31:0]	rt[3] = '{32'h0001_0004, 32'h0010_001c, 32'h0020_0004};
	logic [17:0]	q[$];
	int	err_total = 0, samples_checked = 0, seed = 32'hfb04;
	event	pr;
	function automatic logic [15:0] vw(input logic [1:0] s);
		case (s)
			2'd0: return native_sel_o;
			2'd1: return sticky_sts_o;
			2'd2: return acnt;
			default: return {8'h00, alert_level_o, pin21_o, graphics_busy_n_o,
				system_mgmt_interrupt_n_o, acpi_control_interrupt_o,
				deep_sleep_transition_n_o, decode_inhibit_o, graphics_busy_valid_o};
		endcase
	endfunction : vw
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (alert_event_o === 1'b1) acnt <= acnt + 16'h0001;
	gpmap_board gpmap_board_i (.level_i(pins), .pin_o(general_input_i));
	gpmap_top gpmap_top_i (.*);
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : w
	task automatic ex(input logic [1:0] s, input logic [15:0] e);
		q.push_back({s, e});
		-> pr;
	endtask : ex
	task automatic sel(input logic [15:0] g);
		gp_select_i = g;
		gp_select_we_i = '1;
		w(1);
		gp_select_we_i = '0;
	endtask : sel
	task automatic summarize;
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	always @(pr) while (q.size() > 0) begin
		samples_checked++;
		if (vw(q[0][17:16]) !== q[0][15:0]) begin
			err_total++;
			$display("unexpected t=%0t got=%h exp=%h", $time, vw(q[0][17:16]), q[0][15:0]);
		end
		void'(q.pop_front());
	end
	initial begin
		#20000 err_total++;
		summarize();
	end
	initial begin
		w(5);
		srst_i = '0;
		w(1);
		ex(0, '1);
		ex(1, '0);
		ex(3, 16'h0014);
		sel('1);
		{pins, active_high_i} = $random(seed);
		w(10);
		ex(1, (~active_high_i | ~(pins ^ active_high_i)) & 16'hfffe);
		{pins, active_high_i} = 32'h0000_ffff;
		w(8);
		sticky_clr_i = '1;
		w(2);
		sticky_clr_i = '0;
		ex(1, '0);
		route_smi_i = 16'h0021;
		route_sci_i = 16'h0030;
		foreach (rt[i]) begin
			pins = rt[i][31:16];
			w(8);
			ex(3, rt[i][15:0]);
		end
		pins = '0;
		w(8);
		heartbeat_mode_i = '1;
		sel(16'hf7ff);
		pins = 16'h0800;
		w(10);
		ex(2, 16'h0001);
		sel('1);
		pins = '0;
		w(10);
		ex(2, 16'h0002);
		heartbeat_mode_i = '0;
		w(2);
		pins = 16'h0800;
		w(10);
		ex(2, 16'h0002);
		sel('0);
		{deep_sleep_req_i, decode_inhibit_req_i} = 2'h3;
		pins = 16'h0840;
		for (int m = 0; m < 2; m++) begin
			mobile_cfg_i = m[0];
			w(6);
			ex(3, m[0] ? 16'h00b1 : 16'h00f6);
		end
		w(1);
		summarize();
	end
endmodule : gpmap_top_tb
